// ===== common/adc_regs_pkg.sv
// register map, field positions, reset values and encodings of the result and pad bank
// assumes a single system clock; all users import the whole package
package adc_regs_pkg;
  // register indices; the bus address is the index times four
  localparam logic [7:0] idx_osc_control   = 8'h30; // oscillator control
  localparam logic [7:0] idx_pad_out_ctrl  = 8'h40; // pad output and direction
  localparam logic [7:0] idx_pad_in_state  = 8'h41; // sampled pad levels
  localparam logic [7:0] idx_result_low    = 8'h50; // result low byte
  localparam logic [7:0] idx_result_high   = 8'h51; // result high byte
  localparam logic [7:0] idx_conv_cfg0     = 8'h52; // ratio and count selects
  localparam logic [7:0] idx_conv_cfg1     = 8'h53; // bias selects and stage enables
  localparam logic [7:0] idx_conv_cfg2     = 8'h54;
  localparam logic [7:0] idx_conv_cfg3     = 8'h55;
  localparam logic [7:0] idx_conv_cfg4     = 8'h56;
  localparam logic [7:0] idx_conv_cfg5     = 8'h57;
  localparam logic [7:0] idx_op_mode       = 8'h70; // reference routing
  localparam int         addr_w            = 10;    // byte address width, index times four

  // field positions
  localparam int pos_osc_enable_bit    = 0;
  localparam int pos_pad0_drive_value  = 0;
  localparam int pos_pad1_drive_value  = 1;
  localparam int pos_pad0_direction    = 4;
  localparam int pos_pad1_direction    = 5;
  localparam int pos_elementary_sel    = 5;  // two bits in cfg0
  localparam int pos_ratio_sel         = 2;  // three bits in cfg0
  localparam int pos_converter_bias    = 6;  // two bits in cfg1
  localparam int pos_amplifier_bias    = 4;  // two bits in cfg1
  localparam int pos_ref_out_pad0      = 1;
  localparam int pos_ref_in_pad1       = 0;

  // writable masks, unused bits ignored
  localparam logic [7:0] mask_osc     = 8'h01;
  localparam logic [7:0] mask_pad_out = 8'h33;
  localparam logic [7:0] mask_cfg0    = 8'hfe;
  localparam logic [7:0] mask_cfg4    = 8'h7f;
  localparam logic [7:0] mask_cfg5    = 8'h7f; // busy bit is read-only
  localparam logic [7:0] mask_mode    = 8'h3f;

  // reset values
  localparam logic [7:0] rst_osc      = 8'h01;
  localparam logic [7:0] rst_pad_out  = 8'h30;
  localparam logic [7:0] rst_cfg0     = 8'h28;
  localparam logic [7:0] rst_cfg1     = 8'hf0;
  localparam logic [7:0] rst_cfg2     = 8'h00;
  localparam logic [7:0] rst_cfg3     = 8'h0c;
  localparam logic [7:0] rst_cfg4     = 8'h00;
  localparam logic [7:0] rst_cfg5     = 8'h00;
  localparam logic [7:0] rst_mode     = 8'h04;
  localparam logic [15:0] rst_result  = 16'h0000;

  // result code limits and resolution
  localparam int          res_bits    = 16;
  localparam logic [15:0] code_max    = 16'h7fff;
  localparam logic [15:0] code_min    = 16'h8000;
  localparam int          raw_w       = 24;      // raw accumulator width from the converter

  // bias encodings
  localparam logic [1:0] bias_quarter = 2'b00;
  localparam logic [1:0] bias_half    = 2'b01;
  localparam logic [1:0] bias_full    = 2'b11;

  // value read from an unmapped index
  localparam logic [31:0] read_unmapped = 32'h0000_0000;
endpackage

// ===== verilog/result_formatter.sv
// saturates a raw signed converter value to sixteen bits and forces the unused low bits
// assumes raw value and selects are stable while valid is high; one clock
`timescale 1ns/1ns
module result_formatter #(
  parameter int RAW_W = adc_regs_pkg::raw_w
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 raw_valid,     // one-cycle pulse, conversion done
  input  wire logic [RAW_W-1:0]     raw_value,     // signed raw code
  input  wire logic [2:0]           ratio_sel,     // oversampling ratio select
  input  wire logic [1:0]           count_sel,     // elementary count select
  output logic                      code_valid,    // one-cycle pulse
  output logic [15:0]               code_out       // formatted code
);
  import adc_regs_pkg::*;

  if (RAW_W < 16) begin : g_raw_check
    $error("raw width below sixteen bits");
  end

  // effective resolution: 2*(3+ratio)+count, capped at sixteen
  function automatic logic [4:0] resolution(input logic [2:0] r, input logic [1:0] c);
    logic [5:0] n;
    n = 6'(2 * (3 + int'(r)) + int'(c));
    if (n > 6'(res_bits)) n = 6'(res_bits);
    return n[4:0];
  endfunction

  logic [15:0] sat_code;    // clamped value
  logic [15:0] fill_mask;   // ones over the unused low bits
  logic [15:0] fill_top;    // one in highest unused bit
  logic [4:0]  n_res;       // effective resolution

  // clamp to the nearest full-scale code
  always_comb begin
    if (!raw_value[RAW_W-1] && (raw_value > RAW_W'(code_max)))
      sat_code = code_max;
    else if (raw_value[RAW_W-1] && ($signed(raw_value) < $signed({{(RAW_W-16){1'b1}}, code_min})))
      sat_code = code_min;
    else
      sat_code = raw_value[15:0];
  end

  // unused-bit pattern: a one then zeros; none at full resolution
  always_comb begin
    n_res     = resolution(ratio_sel, count_sel);
    fill_mask = 16'hffff >> n_res;
    fill_top  = (n_res < 5'(res_bits)) ? (16'h8000 >> n_res) : 16'h0000;
  end

  // register the formatted code
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      code_out   <= rst_result;
      code_valid <= 1'b0;
    end else begin
      code_valid <= raw_valid;
      if (raw_valid) code_out <= (sat_code & ~fill_mask) | fill_top;
    end
  end
endmodule

// ===== verilog/pad_mux.sv
// two general-purpose pads with direction, drive value and reference overrides
// assumes pad inputs are synchronous to the system clock
`timescale 1ns/1ns
module pad_mux (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] pad_ctrl,      // pad output control register
  input  wire logic       ref_out_pad0,  // reference driven out on pad 0
  input  wire logic       ref_in_pad1,   // pad 1 takes an external reference
  input  wire logic [1:0] pad_in,        // pin levels
  output logic      [1:0] pad_out,       // pin drive values
  output logic      [1:0] pad_oe,        // pin drive enables
  output logic      [1:0] pad_sampled    // sampled levels
);
  import adc_regs_pkg::*;

  // drive only when direction is output and no reference owns the pad
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pad_out <= 2'b00;
      pad_oe  <= 2'b00;
    end else begin
      pad_oe[0]  <= pad_ctrl[pos_pad0_direction] & ~ref_out_pad0;
      pad_out[0] <= pad_ctrl[pos_pad0_drive_value];
      pad_oe[1]  <= pad_ctrl[pos_pad1_direction] & ~ref_in_pad1;
      pad_out[1] <= pad_ctrl[pos_pad1_drive_value];
    end
  end

  // sampled level; no reset value is promised, zero chosen
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pad_sampled <= 2'b00;
    else        pad_sampled <= pad_in;
  end
endmodule

// ===== verilog/adc_result_regs.sv
// register bank: conversion result, bias and enable settings, oscillator and pads
// assumes an avalon-mm master on clk_sys; pins synchronous to clk_sys
`timescale 1ns/1ns

// How it works
// - result is sixteen-bit two's complement
// - out-of-range input clamps to 7fff or 8000
// - unused low bits: one then zeros
// - result low at 50, high at 51
// - bias selects: 00 quarter, 01 half, 11 full
// - amplifiers and converter may be fully disabled
// - writes to unused bits have no effect
// - reset loads every documented reset value
// - oscillator enable at 30 bit 0, resets one
// - pad directions bits 4,5; reset output
// - pad 1 drive value, gated by reference input
// - pad 0 drive value, gated by reference output
// - pad levels readable at 41
// - ratio is 2^(3+sel), count 2^sel
// - resolution 2log2 ratio plus log2 count
// - mode bits route reference onto pads
module adc_result_regs #(
  parameter int RAW_W = adc_regs_pkg::raw_w
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_b,
  input  wire logic [adc_regs_pkg::addr_w-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [31:0]                     avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic      [31:0]                     avs_readdata,
  output logic                                 avs_waitrequest,
  input  wire logic                            raw_valid,
  input  wire logic [RAW_W-1:0]                raw_value,
  input  wire logic                            conv_busy,
  input  wire logic [1:0]                      pad_in,
  output logic      [1:0]                      pad_out,
  output logic      [1:0]                      pad_oe,
  output logic                                 osc_enable,
  output logic      [1:0]                      converter_bias,
  output logic      [1:0]                      amplifier_bias,
  output logic      [3:0]                      stage_enable,
  output logic      [2:0]                      oversampling_ratio_select,
  output logic      [1:0]                      elementary_count_select,
  output logic      [10:0]                     oversampling_ratio,
  output logic      [3:0]                      elementary_count,
  output logic                                 ref_output_on_pad0,
  output logic                                 ref_input_on_pad1
);
  import adc_regs_pkg::*;

  if (RAW_W < 16 || RAW_W > 32) begin : g_raw_check
    $error("raw width must lie in 16..32");
  end

  // bus handshake state
  typedef enum logic [1:0] {bus_idle, bus_answer, bus_release} bus_state_e;
  bus_state_e bus_reg;            // current bus phase

  // stored registers
  logic [7:0]  osc_reg;           // oscillator control
  logic [7:0]  pad_ctrl_reg;      // pad output control
  logic [7:0]  cfg_reg [0:5];     // conversion configuration registers
  logic [7:0]  mode_reg;          // operating mode
  logic [15:0] result_reg;        // last completed conversion, both bytes

  // derived and sub-block signals
  logic [15:0] code_w;            // formatted code
  logic        code_valid_w;      // formatted code ready
  logic [1:0]  pad_sampled_w;     // sampled pad levels
  logic [7:0]  word_idx;          // register index from byte address
  logic        wr_hit;            // write accepted this cycle
  logic [7:0]  wdata;             // low lane write data

  // decode an index into the configuration slot, or 7 if not one
  function automatic logic [2:0] cfg_slot(input logic [7:0] idx);
    if (idx >= idx_conv_cfg0 && idx <= idx_conv_cfg5) return 3'(idx - idx_conv_cfg0);
    else return 3'd7;
  endfunction

  // writable mask of a configuration slot
  function automatic logic [7:0] cfg_mask(input logic [2:0] s);
    if (s == 3'd0)      return mask_cfg0;
    else if (s == 3'd4) return mask_cfg4;
    else if (s == 3'd5) return mask_cfg5;
    else                return 8'hff;
  endfunction

  // reset value of a configuration slot
  function automatic logic [7:0] cfg_reset(input logic [2:0] s);
    if (s == 3'd0)      return rst_cfg0;
    else if (s == 3'd1) return rst_cfg1;
    else if (s == 3'd2) return rst_cfg2;
    else if (s == 3'd3) return rst_cfg3;
    else if (s == 3'd4) return rst_cfg4;
    else                return rst_cfg5;
  endfunction

  assign word_idx = avs_address[9:2];
  assign wdata    = avs_writedata[7:0];
  assign wr_hit   = (bus_reg == bus_idle) && avs_write && avs_byteenable[0];

  // formatter: clamp and fill pattern
  result_formatter #(
    .RAW_W (RAW_W)
  ) u_fmt (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .raw_valid  (raw_valid),
    .raw_value  (raw_value),
    .ratio_sel  (cfg_reg[0][pos_ratio_sel +: 3]),
    .count_sel  (cfg_reg[0][pos_elementary_sel +: 2]),
    .code_valid (code_valid_w),
    .code_out   (code_w)
  );

  // pad logic
  pad_mux u_pads (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .pad_ctrl     (pad_ctrl_reg),
    .ref_out_pad0 (mode_reg[pos_ref_out_pad0]),
    .ref_in_pad1  (mode_reg[pos_ref_in_pad1]),
    .pad_in       (pad_in),
    .pad_out      (pad_out),
    .pad_oe       (pad_oe),
    .pad_sampled  (pad_sampled_w)
  );

  // bus phases: every access waits one cycle, answers, then one release cycle
  // the release cycle keeps a held request from being taken twice
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_reg <= bus_idle;
    end else begin
      case (bus_reg)
        bus_idle: begin
          if (avs_read || avs_write) bus_reg <= bus_answer;
        end
        bus_answer: begin
          bus_reg <= bus_release;
        end
        default: begin
          bus_reg <= bus_idle;
        end
      endcase
    end
  end

  // waitrequest low only in the answer cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) avs_waitrequest <= 1'b1;
    else        avs_waitrequest <= !((bus_reg == bus_idle) && (avs_read || avs_write));
  end

  // oscillator control, masked so unused bits stay zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) osc_reg <= rst_osc;
    else if (wr_hit && word_idx == idx_osc_control)
      osc_reg <= wdata & mask_osc;
  end

  // pad control: directions reset to output, drive values to zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) pad_ctrl_reg <= rst_pad_out;
    else if (wr_hit && word_idx == idx_pad_out_ctrl)
      pad_ctrl_reg <= wdata & mask_pad_out;
  end

  // operating mode: reference routing bits and others
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) mode_reg <= rst_mode;
    else if (wr_hit && word_idx == idx_op_mode)
      mode_reg <= wdata & mask_mode;
  end

  // configuration registers, one per slot
  for (genvar g = 0; g < 6; g++) begin : g_cfg
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cfg_reg[g] <= cfg_reset(3'(g));
      else if (wr_hit && cfg_slot(word_idx) == 3'(g))
        cfg_reg[g] <= wdata & cfg_mask(3'(g));
    end
  end

  // both bytes captured together from one code; a new code landing between a low and a high read replaces both bytes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) result_reg <= rst_result;
    else if (code_valid_w) result_reg <= code_w;
  end

  // settings driven to the analogue side
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_enable                <= rst_osc[pos_osc_enable_bit];
      converter_bias            <= rst_cfg1[pos_converter_bias +: 2];
      amplifier_bias            <= rst_cfg1[pos_amplifier_bias +: 2];
      stage_enable              <= rst_cfg1[3:0];
      oversampling_ratio_select <= rst_cfg0[pos_ratio_sel +: 3];
      elementary_count_select   <= rst_cfg0[pos_elementary_sel +: 2];
      oversampling_ratio        <= 11'd8 << rst_cfg0[pos_ratio_sel +: 3];
      elementary_count          <= 4'd1 << rst_cfg0[pos_elementary_sel +: 2];
      ref_output_on_pad0        <= 1'b0;
      ref_input_on_pad1         <= 1'b0;
    end else begin
      osc_enable                <= osc_reg[pos_osc_enable_bit];
      // bias select 10 is not listed; the analogue side treats it as half
      converter_bias            <= cfg_reg[1][pos_converter_bias +: 2];
      amplifier_bias            <= cfg_reg[1][pos_amplifier_bias +: 2];
      // all-zero enables switch every stage off for idle
      stage_enable              <= cfg_reg[1][3:0];
      oversampling_ratio_select <= cfg_reg[0][pos_ratio_sel +: 3];
      elementary_count_select   <= cfg_reg[0][pos_elementary_sel +: 2];
      oversampling_ratio        <= 11'd8 << cfg_reg[0][pos_ratio_sel +: 3];
      elementary_count          <= 4'd1 << cfg_reg[0][pos_elementary_sel +: 2];
      ref_output_on_pad0        <= mode_reg[pos_ref_out_pad0];
      ref_input_on_pad1         <= mode_reg[pos_ref_in_pad1];
    end
  end

  // read data, loaded at request acceptance, valid in the answer cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= read_unmapped;
    end else if ((bus_reg == bus_idle) && avs_read) begin
      if (word_idx == idx_osc_control)       avs_readdata <= {24'h0, osc_reg};
      else if (word_idx == idx_pad_out_ctrl) avs_readdata <= {24'h0, pad_ctrl_reg};
      else if (word_idx == idx_pad_in_state) avs_readdata <= {30'h0, pad_sampled_w};
      else if (word_idx == idx_result_low)   avs_readdata <= {24'h0, result_reg[7:0]};
      else if (word_idx == idx_result_high)  avs_readdata <= {24'h0, result_reg[15:8]};
      else if (word_idx == idx_conv_cfg5)
        avs_readdata <= {24'h0, conv_busy, cfg_reg[5][6:0]};
      else if (cfg_slot(word_idx) != 3'd7)
        avs_readdata <= {24'h0, cfg_reg[cfg_slot(word_idx)]};
      else if (word_idx == idx_op_mode)      avs_readdata <= {24'h0, mode_reg};
      else                                   avs_readdata <= read_unmapped;
    end
  end
endmodule

// ===== sim/pad_partner.sv
// far side of the two pads: an outside driver per pin and the resulting wire level
// assumes the bench sets ext_drive and ext_level; pins are plain push-pull lines
`timescale 1ns/1ns
module pad_partner (
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe,
  input  wire logic [1:0] ext_drive,
  input  wire logic [1:0] ext_level,
  output logic      [1:0] pad_in
);
  // the device wins where it drives; a pin nobody drives shows the inverse of the
  // device value, so a stale level can never pass for a sampled one
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_drive[i]) begin
        pad_in[i] = ext_level[i];
      end else begin
        pad_in[i] = ~pad_out[i];
      end
    end
  end
endmodule

// ===== sim/adc_checker.sv
// concurrent checks on the bus answer and the control outputs of the register bank
// assumes it is bound into adc_result_regs and sees only its ports
`timescale 1ns/1ns
module adc_checker (
  input wire logic                            clk_sys,
  input wire logic                            rst_b,
  input wire logic [adc_regs_pkg::addr_w-1:0] avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic [31:0]                     avs_writedata,
  input wire logic [3:0]                      avs_byteenable,
  input wire logic [31:0]                     avs_readdata,
  input wire logic                            avs_waitrequest,
  input wire logic [1:0]                      pad_out,
  input wire logic [1:0]                      pad_oe,
  input wire logic                            osc_enable,
  input wire logic [1:0]                      converter_bias,
  input wire logic [1:0]                      amplifier_bias,
  input wire logic [3:0]                      stage_enable,
  input wire logic [2:0]                      oversampling_ratio_select,
  input wire logic [1:0]                      elementary_count_select,
  input wire logic [10:0]                     oversampling_ratio,
  input wire logic [3:0]                      elementary_count,
  input wire logic                            ref_input_on_pad1
);
  import adc_regs_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [7:0] idx;  // register index of the current request
  logic       wr_ok; // write answered with the low byte enabled
  assign idx   = avs_address[9:2];
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  a_wait_one: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_req_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered in time");
  a_read_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && idx == 8'h7f |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_osc_write: assert property (
    wr_ok && idx == 8'h30 |=> osc_enable == $past(avs_writedata[0]))
    else $error("oscillator enable not following write");
  a_pad_dir: assert property (
    wr_ok && idx == 8'h40 |=> pad_oe[1] == ($past(avs_writedata[5]) && !ref_input_on_pad1))
    else $error("pad 1 direction not following write");
  a_pad_drive: assert property (
    wr_ok && idx == 8'h40 |=> !pad_oe[1] || pad_out[1] == $past(avs_writedata[1]))
    else $error("pad 1 drive value wrong");
  a_bias_write: assert property (
    wr_ok && idx == 8'h53 |=>
    {converter_bias, amplifier_bias, stage_enable} == $past(avs_writedata[7:0]))
    else $error("bias or enable not following write");
  a_ratio_pow: assert property (
    oversampling_ratio == (11'd8 << oversampling_ratio_select))
    else $error("ratio not a power of two of the select");
  a_count_pow: assert property (elementary_count == (4'd1 << elementary_count_select))
    else $error("count not a power of two of the select");
  a_ref_pad1: assert property (ref_input_on_pad1 |-> !pad_oe[1])
    else $error("pad 1 driven while taking a reference");
endmodule
bind adc_result_regs adc_checker u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pad_out(pad_out), .pad_oe(pad_oe),
  .osc_enable(osc_enable), .converter_bias(converter_bias), .amplifier_bias(amplifier_bias),
  .stage_enable(stage_enable), .oversampling_ratio_select(oversampling_ratio_select),
  .elementary_count_select(elementary_count_select), .oversampling_ratio(oversampling_ratio),
  .elementary_count(elementary_count), .ref_input_on_pad1(ref_input_on_pad1));

// ===== sim/tb_top.sv
// self-checking bench for the result and pad register bank
// assumes the bank answers avalon-mm with waitrequest; pads closed by pad_partner
`timescale 1ns/1ns
module tb_top;
  import adc_regs_pkg::*;
  logic              clk_sys, rst_b, avs_read, avs_write, raw_valid, avs_waitrequest;
  logic [addr_w-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata, rd;
  logic [3:0]        avs_byteenable, stage_enable, elementary_count;
  logic [23:0]       raw_value;
  logic [1:0]        pad_in, pad_out, pad_oe, ext_drive, ext_level, cbias, abias, csel;
  logic [2:0]        rsel;
  logic [10:0]       ratio;
  logic              osc_enable, ref0, ref1;
  int                n_errors = 0;
  int                checked = 0;
  adc_result_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .raw_valid(raw_valid), .raw_value(raw_value), .conv_busy(1'b0), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .osc_enable(osc_enable), .converter_bias(cbias),
    .amplifier_bias(abias), .stage_enable(stage_enable), .oversampling_ratio_select(rsel),
    .elementary_count_select(csel), .oversampling_ratio(ratio),
    .elementary_count(elementary_count), .ref_output_on_pad0(ref0), .ref_input_on_pad1(ref1));
  pad_partner u_pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_drive(ext_drive),
    .ext_level(ext_level), .pad_in(pad_in));
  // free-running system clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus cycle: request held until waitrequest is sampled low, data taken there
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_address    <= {idx, 2'b00};
    avs_writedata  <= {24'h0, wd};
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      n_errors++;
      wrap_up();
    end else begin
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, 4'hf);
    repeat (2) @(posedge clk_sys); // outputs follow one cycle after the write
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'hf);
    check("register", rd, {24'h0, exp});
  endtask
  // expected formatted code: clamp, then one-then-zeros below the resolution
  function automatic logic [15:0] fmt(input int raw, input int r, input int c);
    int n;
    logic [15:0] code;
    n = (2 * (3 + r) + c > 16) ? 16 : 2 * (3 + r) + c;
    code = (raw > 32767) ? 16'h7fff : (raw < -32768) ? 16'h8000 : raw[15:0];
    if (n < 16) begin
      code = (code & ~((16'h1 << (16 - n)) - 16'h1)) | (16'h1 << (15 - n));
    end
    return code;
  endfunction
  task automatic t_reset();
    logic [7:0] ix[8] = '{8'h30, 8'h40, 8'h52, 8'h53, 8'h55, 8'h70, 8'h50, 8'h51};
    logic [7:0] ex[8] = '{8'h01, 8'h30, 8'h28, 8'hf0, 8'h0c, 8'h04, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rdchk(ix[i], ex[i]);
    end
    check("pad_oe", pad_oe, 2'b11);
    check("osc", osc_enable, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_masks();
    wr(8'h30, 8'hfe);
    check("osc", osc_enable, 1'b0);
    rdchk(8'h30, 8'h00);
    bus(1'b1, 8'h30, 8'hff, 4'h0);
    rdchk(8'h30, 8'h00);
    wr(8'h30, 8'hff);
    rdchk(8'h30, 8'h01);
    wr(8'h40, 8'hff);
    rdchk(8'h40, 8'h33);
    wr(8'h50, 8'haa);
    rdchk(8'h50, 8'h00);
    rdchk(8'h7f, 8'h00);
    $display("test masks done");
  endtask
  task automatic t_pads();
    wr(8'h40, 8'h03);
    check("pad_oe in", pad_oe, 2'b00);
    ext_level <= 2'b10;
    wr(8'h40, 8'h03);
    rdchk(8'h41, 8'h02);
    ext_level <= 2'b01;
    wr(8'h40, 8'h03);
    rdchk(8'h41, 8'h01);
    wr(8'h40, 8'h31);
    check("pad drive", {pad_oe, pad_out}, 4'b1101);
    wr(8'h40, 8'h32);
    check("pad drive", {pad_oe, pad_out}, 4'b1110);
    wr(8'h70, 8'h07);
    check("refs", {ref0, ref1, pad_oe}, 4'b1100);
    wr(8'h70, 8'h04);
    $display("test pads done");
  endtask
  task automatic t_bias();
    logic [1:0] codes[3] = '{2'b00, 2'b01, 2'b11};
    // sampling rate left at its reset setting (ratio select 2, count select 1), inside every bias limit
    for (int i = 0; i < 3; i++) begin
      wr(8'h53, {codes[i], codes[i], 4'hf});
      check("bias", {cbias, abias, stage_enable}, {codes[i], codes[i], 4'hf});
    end
    wr(8'h53, 8'hf0);
    check("stages off", stage_enable, 4'h0);
    $display("test bias done");
  endtask
  task automatic t_result();
    int rs[6]  = '{5, 7, 5, 0, 0, 3};
    int cs[6]  = '{0, 3, 0, 0, 0, 1};
    int raw[6] = '{32'h1234, 32'h100000, -65536, 0, -1, 32'h7f};
    logic [15:0] got;
    for (int i = 0; i < 6; i++) begin
      wr(8'h52, 8'(cs[i] << 5 | rs[i] << 2));
      check("ratio", {ratio, elementary_count}, {11'd8 << rs[i], 4'd1 << cs[i]});
      check("sel", {rsel, csel}, {3'(rs[i]), 2'(cs[i])});
      @(posedge clk_sys);
      raw_value <= raw[i][23:0];
      raw_valid <= 1'b1;
      @(posedge clk_sys);
      raw_valid <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus(1'b0, 8'h50, 8'h00, 4'hf);
      got[7:0] = rd[7:0];
      bus(1'b0, 8'h51, 8'h00, 4'hf);
      got[15:8] = rd[7:0];
      check("result", got, fmt(raw[i], rs[i], cs[i]));
    end
    $display("test result done");
  endtask
  // reset, then each scenario in turn
  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, raw_valid} = 3'b000;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h0;
    raw_value = '0;
    ext_drive = 2'b11;
    ext_level = 2'b00;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_masks();
    t_pads();
    t_bias();
    t_result();
    wrap_up();
  end
endmodule
